// [hw/frerase_pkg.sv]
// Package for the flash row erase sequencer: register map, fields, timing.
// Assumes a 200 MHz core clock and an AXI4-Lite register bus.
package frerase_pkg;

  // ==========================================================
  // Register indices (printed offsets, byte address = 4*index)
  localparam logic [11:0] IDX_INT_EN2 = 12'hfa0;
  localparam logic [11:0] IDX_INT_FLAG2 = 12'hfa1;
  localparam logic [11:0] IDX_INT_PRIO2 = 12'hfa2;
  localparam logic [11:0] IDX_NVM_CONTROL = 12'hfa6;
  localparam logic [11:0] IDX_NVM_UNLOCK = 12'hfa7;
  localparam logic [11:0] IDX_NVM_DATA = 12'hfa8;
  localparam logic [11:0] IDX_NVM_ADDRESS = 12'hfa9;
  localparam logic [11:0] IDX_INT_CTRL = 12'hff2;
  localparam logic [11:0] IDX_TPTR_LO = 12'hf00;
  localparam logic [11:0] IDX_TPTR_MID = 12'hf01;
  localparam logic [11:0] IDX_TPTR_HI = 12'hf02;
  localparam logic [11:0] IDX_STATUS = 12'hf03;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_INT_EN2 = 8'h00;
  localparam logic [7:0] RST_INT_FLAG2 = 8'h00;
  localparam logic [7:0] RST_INT_PRIO2 = 8'h1f;
  localparam logic [7:0] RST_NVM_DATA = 8'h00;
  localparam logic [7:0] RST_NVM_ADDRESS = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;

  // ==========================================================
  // Control register bit positions
  localparam int BIT_PGM_SEL = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_ERASE_SEL = 4;
  localparam int BIT_WR_ERR = 3;
  localparam int BIT_WR_EN = 2;
  localparam int BIT_START = 1;
  localparam int BIT_RD = 0;
  localparam int BIT_GLOBAL_IE = 7;
  localparam int BIT_ROW_DONE = 4;
  localparam logic [7:0] CTRL_RW_MASK = 8'hd4;
  localparam logic [7:0] INT_FLAG2_MASK = 8'h1e;
  localparam logic [7:0] INT_PRIO2_MASK = 8'h1e;

  // ==========================================================
  // Unlock keys and pointer fields
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int TP_WIDTH = 22;
  localparam int ROW_LSB = 6;
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 64;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FRE_IDLE = 2'b00,
    FRE_KEY1 = 2'b01,
    FRE_ARMED = 2'b10
  } frerase_unlock_type;

  typedef struct packed {
    logic req;
    logic [TP_WIDTH-ROW_LSB-1:0] row;
  } frerase_erase_type;

endpackage

// [hw/frerase_top.sv]
// Flash row erase sequencer with AXI4-Lite register slave.
// Assumes a flash macro that erases the row presented while erase_o.req is
// high; the core honours cpu_stall.
//
// Contract
// - Erase unit is one row of 32 words, 64 bytes.
// - No single-word erase; every erase covers a whole row.
// - Bulk erase only via external programmer or serial programming path.
// - Table pointer bits 21:6 select the row; bits 5:0 ignored.
// - Program-memory select must be set to target program flash.
// - With write enable clear no erase or write starts.
// - Erase-select set makes the next started operation a row erase.
// - Erase starts only after 0x55 then 0xaa to unlock, then start.
// - Start bit after valid unlock begins the row erase.
// - Instruction execution halts during the erase.
// - Internal timer ends the erase after about 2 ms.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module frerase_top
  import frerase_pkg::*;
#(
  parameter int ERASE_COUNT = frerase_pkg::ERASE_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash macro and core
  output frerase_pkg::frerase_erase_type erase_o,
  output logic cpu_stall
);
  import frerase_pkg::*;

  localparam int CW = $clog2(ERASE_COUNT + 1);

  // ==========================================================
  // Reset synchroniser
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  function automatic logic [11:0] word_idx(input logic [15:0] a);
    return a[13:2];
  endfunction

  function automatic logic known(input logic [11:0] i);
    return i == IDX_INT_EN2 || i == IDX_INT_FLAG2 || i == IDX_INT_PRIO2 ||
      i == IDX_NVM_CONTROL || i == IDX_NVM_UNLOCK ||
      i == IDX_NVM_DATA || i == IDX_NVM_ADDRESS || i == IDX_INT_CTRL ||
      i == IDX_TPTR_LO || i == IDX_TPTR_MID ||
      i == IDX_TPTR_HI || i == IDX_STATUS;
  endfunction

  // ==========================================================
  // Write channel state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [11:0] aw_idx_q, aw_idx_d;
  logic [7:0] w_byte_q, w_byte_d;
  logic w_en_q, w_en_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;

  // Registers
  logic [7:0] int_en2_q, int_en2_d, int_flag2_q, int_flag2_d;
  logic [7:0] int_prio2_q, int_prio2_d;
  logic [7:0] ctrl_q, ctrl_d, data_q, data_d, addr_q, addr_d;
  logic [7:0] int_ctrl_q, int_ctrl_d;
  logic [TP_WIDTH-1:0] tp_q, tp_d;
  frerase_unlock_type unl_q, unl_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic [TP_WIDTH-ROW_LSB-1:0] row_q, row_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Core stalls while erasing, so bus writes are held off too
  assign s_axi_awready = !aw_have_q && !busy_q && rst_s2_q;
  assign s_axi_wready = !w_have_q && !busy_q && rst_s2_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q && rst_s2_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign erase_o.req = busy_q;
  assign erase_o.row = row_q;
  assign cpu_stall = busy_q;

  // ==========================================================
  // Write channel next state
  always_comb
  begin
    aw_have_d = aw_have_q;
    aw_idx_d = aw_idx_q;
    w_have_d = w_have_q;
    w_byte_d = w_byte_q;
    w_en_d = w_en_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      aw_idx_d = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      w_byte_d = s_axi_wdata[7:0];
      w_en_d = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_d = 1'b0;
    // Both halves held: execute and answer together
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = known(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================
  // Write channel registers
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      aw_have_q <= 1'b0;
      aw_idx_q <= '0;
      w_have_q <= 1'b0;
      w_byte_q <= '0;
      w_en_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_idx_q <= aw_idx_d;
      w_have_q <= w_have_d;
      w_byte_q <= w_byte_d;
      w_en_q <= w_en_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ==========================================================
  // Register file and erase timer next state
  always_comb
  begin
    logic start;
    start = 1'b0;
    int_en2_d = int_en2_q;
    int_flag2_d = int_flag2_q;
    int_prio2_d = int_prio2_q;
    ctrl_d = ctrl_q;
    data_d = data_q;
    addr_d = addr_q;
    int_ctrl_d = int_ctrl_q;
    tp_d = tp_q;
    unl_d = unl_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    row_d = row_q;

    if (wr_fire)
    begin
      if (w_en_q)
      begin
        // Any write with byte lane 0 enabled, other than the expected key, breaks the unlock
        unl_d = FRE_IDLE;
        unique case (aw_idx_q)
          IDX_NVM_UNLOCK:
            if (w_byte_q == KEY_FIRST)
              unl_d = FRE_KEY1;
            else if (w_byte_q == KEY_SECOND && unl_q == FRE_KEY1)
              unl_d = FRE_ARMED;
          IDX_NVM_CONTROL:
          begin
            ctrl_d = (ctrl_q & ~CTRL_RW_MASK) | (w_byte_q & CTRL_RW_MASK);
            if (w_byte_q[BIT_START] && !ctrl_q[BIT_START])
            begin
              // Erase needs armed unlock, write enable, program flash
              if (unl_q == FRE_ARMED && w_byte_q[BIT_WR_EN] &&
                  w_byte_q[BIT_PGM_SEL] && !w_byte_q[BIT_CFG_SEL] &&
                  w_byte_q[BIT_ERASE_SEL])
                start = 1'b1;
              else if (unl_q == FRE_ARMED && w_byte_q[BIT_WR_EN])
                ctrl_d[BIT_WR_ERR] = 1'b1; // Unsupported op flagged
            end
          end
          IDX_INT_EN2: int_en2_d = w_byte_q & INT_FLAG2_MASK;
          IDX_INT_FLAG2: int_flag2_d = w_byte_q & INT_FLAG2_MASK;
          IDX_INT_PRIO2: int_prio2_d = w_byte_q & INT_PRIO2_MASK;
          IDX_NVM_DATA: data_d = w_byte_q;
          IDX_NVM_ADDRESS: addr_d = w_byte_q;
          IDX_INT_CTRL: int_ctrl_d = w_byte_q;
          IDX_TPTR_LO: tp_d[7:0] = w_byte_q;
          IDX_TPTR_MID: tp_d[15:8] = w_byte_q;
          IDX_TPTR_HI: tp_d[TP_WIDTH-1:16] = w_byte_q[TP_WIDTH-17:0];
          default: ;
        endcase
      end
    end

    // Only a whole row is ever erased; the low six bits are dropped
    if (start)
    begin
      busy_d = 1'b1;
      ctrl_d[BIT_START] = 1'b1;
      row_d = tp_q[TP_WIDTH-1:ROW_LSB];
      cnt_d = CW'(ERASE_COUNT - 1);
    end
    else if (busy_q)
    begin
      if (cnt_q == '0)
      begin
        busy_d = 1'b0;
        ctrl_d[BIT_START] = 1'b0;
        int_flag2_d[BIT_ROW_DONE] = 1'b1;
      end
      else
        cnt_d = cnt_q - 1'b1;
    end
  end

  // ==========================================================
  // Register file and erase timer registers
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      int_en2_q <= RST_INT_EN2;
      int_flag2_q <= RST_INT_FLAG2;
      int_prio2_q <= RST_INT_PRIO2;
      ctrl_q <= '0;
      data_q <= RST_NVM_DATA;
      addr_q <= RST_NVM_ADDRESS;
      int_ctrl_q <= RST_INT_CTRL;
      tp_q <= '0;
      unl_q <= FRE_IDLE;
      cnt_q <= '0;
      busy_q <= 1'b0;
      row_q <= '0;
    end
    else
    begin
      int_en2_q <= int_en2_d;
      int_flag2_q <= int_flag2_d;
      int_prio2_q <= int_prio2_d;
      ctrl_q <= ctrl_d;
      data_q <= data_d;
      addr_q <= addr_d;
      int_ctrl_q <= int_ctrl_d;
      tp_q <= tp_d;
      unl_q <= unl_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      row_q <= row_d;
    end
  end

  // ==========================================================
  // Read channel next state
  // Reads never touch the unlock, so status can be polled mid-sequence
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_rvalid && s_axi_rready)
      rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = known(word_idx(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = '0;
      unique case (word_idx(s_axi_araddr))
        IDX_INT_EN2: rdata_d[7:0] = int_en2_q;
        IDX_INT_FLAG2: rdata_d[7:0] = int_flag2_q;
        IDX_INT_PRIO2: rdata_d[7:0] = int_prio2_q;
        IDX_NVM_CONTROL: rdata_d[7:0] = ctrl_q;
        IDX_NVM_DATA: rdata_d[7:0] = data_q;
        IDX_NVM_ADDRESS: rdata_d[7:0] = addr_q;
        IDX_INT_CTRL: rdata_d[7:0] = int_ctrl_q;
        IDX_TPTR_LO: rdata_d[7:0] = tp_q[7:0];
        IDX_TPTR_MID: rdata_d[7:0] = tp_q[15:8];
        IDX_TPTR_HI: rdata_d[TP_WIDTH-17:0] = tp_q[TP_WIDTH-1:16];
        IDX_STATUS: rdata_d[2:0] = {busy_q, unl_q};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read channel registers
  always_ff @(posedge core_clk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule // frerase_top

// [dv/frerase_props.sv]
// Port checker for the row erase sequencer.
// Assumes ERASE_COUNT equals the value of the bound instance.
`timescale 1ns/1ps
module frerase_props
  import frerase_pkg::*;
#(parameter int ERASE_COUNT = 20)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Flash and core
  input wire frerase_pkg::frerase_erase_type erase_o,
  input wire logic cpu_stall
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Erase length count and last three writes
  int cnt_q, cnt_d;
  logic [47:0] ah_q, ah_d;
  logic [23:0] dh_q, dh_d;
  always_comb
  begin
    cnt_d = erase_o.req ? cnt_q + 1 : 0;
    ah_d = ah_q;
    dh_d = dh_q;
    if (s_axi_awvalid && s_axi_awready) ah_d = {ah_q[31:0], s_axi_awaddr};
    if (s_axi_wvalid && s_axi_wready) dh_d = {dh_q[15:0], s_axi_wdata[7:0]};
  end
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) {cnt_q, ah_q, dh_q} <= '0;
    else {cnt_q, ah_q, dh_q} <= {cnt_d, ah_d, dh_d};
  // ==========================================================
  // Assertions
  stall_follows_a: assert property (cpu_stall == erase_o.req)
    else $error("stall differs from erase");
  erase_len_a: assert property ($fell(erase_o.req) |-> cnt_q == ERASE_COUNT)
    else $error("erase length wrong");
  erase_max_a: assert property (cnt_q <= ERASE_COUNT)
    else $error("erase too long");
  busy_refuse_a: assert property (erase_o.req |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while erasing");
  row_hold_a: assert property (erase_o.req && $past(erase_o.req) |-> $stable(erase_o.row))
    else $error("row moved during erase");
  start_mode_a: assert property ($rose(erase_o.req) |-> ah_q[15:0] == 16'h3e98
    && (dh_q[7:0] & 8'hd6) == 8'h96)
    else $error("erase without erase mode");
  unlock_keys_a: assert property ($rose(erase_o.req) |-> ah_q[47:16] == 32'h3e9c3e9c
    && dh_q[23:8] == 16'h55aa)
    else $error("erase without unlock");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  cover property ($rose(erase_o.req));
  cover property ($fell(erase_o.req));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // frerase_props
bind frerase_top frerase_props #(.ERASE_COUNT(ERASE_COUNT)) i_props (.*);

// [dv/frerase_top_tb.sv]
// Self-checking bench for the row erase sequencer.
// Drives the register bus itself; erase count shortened to EC cycles.
`timescale 1ns/1ps
module frerase_top_tb;
  import frerase_pkg::*;
  localparam int EC = 20;
  logic core_clk = 1'h0, rst_n = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  frerase_erase_type erase_o;
  logic cpu_stall;
  int fail_count = 0, check_count = 0, cyc = 0, req_cyc = 0;
  frerase_top #(.ERASE_COUNT(EC)) i_dut (.*);
  initial forever #2.5 core_clk = ~core_clk;
  // ==========================================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (erase_o.req === 1'h1) req_cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    logic at, wt, bt;
    n = 0;
    bt = 1'h0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!bt && n < 400)
    begin
      @(negedge core_clk);
      at = s_axi_awvalid && s_axi_awready === 1'h1;
      wt = s_axi_wvalid && s_axi_wready === 1'h1;
      bt = s_axi_bvalid === 1'h1;
      if (bt) chk(s_axi_bresp, er);
      @(posedge core_clk);
      if (at) s_axi_awvalid <= 1'h0;
      if (wt) s_axi_wvalid <= 1'h0;
      n++;
    end
    s_axi_bready <= 1'h0;
    if (!bt) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    logic art, rt;
    n = 0;
    rt = 1'h0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rt && n < 400)
    begin
      @(negedge core_clk);
      art = s_axi_arvalid && s_axi_arready === 1'h1;
      rt = s_axi_rvalid === 1'h1;
      if (rt)
      begin
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, {24'h0, ed});
      end
      @(posedge core_clk);
      if (art) s_axi_arvalid <= 1'h0;
      n++;
    end
    s_axi_rready <= 1'h0;
    if (!rt) chk(32'h0, 32'h1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(16'h3e80, 8'h00);
    rd(16'h3e84, 8'h00);
    rd(16'h3e88, 8'h1f);
    rd(16'h3e98, 8'h00);
    rd(16'h3ea0, 8'h00);
    rd(16'h3ea4, 8'h00);
    rd(16'h3fc8, 8'h00);
    rd(16'h3ff0, 8'h00, RESP_SLVERR);
    wr(16'h3ff0, 8'h55, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(16'h3ea0, 8'h5a);
    s_axi_wstrb <= 4'h1;
    rd(16'h3ea0, 8'h00);
    wr(16'h3ea0, 8'h5a);
    rd(16'h3ea0, 8'h5a);
    rd(16'h3c0c, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_erase();
    int n;
    n = 0;
    wr(16'h3c00, 8'h7f);
    wr(16'h3c04, 8'ha5);
    wr(16'h3c08, 8'h2b);
    wr(16'h3e9c, KEY_FIRST);
    rd(16'h3c0c, 8'h01);
    wr(16'h3e9c, KEY_SECOND);
    rd(16'h3c0c, 8'h02);
    req_cyc = 0;
    wr(16'h3e98, 8'h96);
    while (erase_o.req !== 1'h1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(erase_o.row, {6'h2b, 8'ha5, 2'h1});
    while (erase_o.req === 1'h1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(req_cyc, EC);
    rd(16'h3e84, 8'h10);
    rd(16'h3e98, 8'h94);
    rd(16'h3c0c, 8'h00);
    $display("test erase done");
  endtask
  task automatic try_start(input logic [7:0] k1, input logic [7:0] k2,
                           input logic mid, input logic [7:0] c);
    req_cyc = 0;
    wr(16'h3e9c, k1);
    if (mid) wr(16'h3ea0, 8'h11);
    wr(16'h3e9c, k2);
    wr(16'h3e98, c);
    repeat (30) @(posedge core_clk);
    chk(req_cyc, 0);
  endtask
  task automatic t_refuse();
    try_start(8'h55, 8'haa, 1'h1, 8'h96);
    try_start(8'haa, 8'h55, 1'h0, 8'h96);
    try_start(8'h55, 8'haa, 1'h0, 8'h92);
    try_start(8'h55, 8'haa, 1'h0, 8'h86);
    try_start(8'h55, 8'haa, 1'h0, 8'hd6);
    try_start(8'h55, 8'haa, 1'h0, 8'h16);
    rd(16'h3e98, 8'h1c);
    $display("test refuse done");
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_erase();
    t_refuse();
    wrap_up();
  end
endmodule // frerase_top_tb
